// file: rtl/aie_core.sv
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE1] File add sums accumulator and file; destination bit clear writes the accumulator.
// [RULE2] File add with destination bit set writes the sum back to the file.
// [RULE3] Access bit clear resolves the file address in the access bank.
// [RULE4] Access bit set uses the bank select register to choose the bank.
// [RULE5] Extended set, access clear and address up to 95 use indexed offset.
// [RULE6] Any 8-bit file address and either destination or access bit is accepted.
// [RULE7] Both adds take one word and four phases, and update all five arithmetic flags.
module aie_core
  import aie_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [11:0] dmem_addr_o,
  output logic dmem_rd_o,
  input wire logic [7:0] dmem_rdata_i,
  output logic dmem_we_o,
  output logic [7:0] dmem_wdata_o
);
  // ==========================================================
  // State
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic aw_got_ff, nxt_aw_got;
  logic w_got_ff, nxt_w_got;
  logic [AXI_AW-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  aie_state_t state_ff, nxt_state;
  logic ext_en_ff, nxt_ext_en;
  logic [15:0] instr_ff, nxt_instr;
  logic [7:0] wreg_ff, nxt_wreg;
  logic [3:0] bank_select_register_ff, nxt_bank_select_register;
  logic [11:0] fsr2_ff, nxt_fsr2;
  logic [4:0] flags_ff, nxt_flags;
  logic unsup_ff, nxt_unsup;
  logic [7:0] sum_ff, nxt_sum;
  logic [4:0] pend_flags_ff, nxt_pend_flags;
  logic [11:0] eaddr_ff, nxt_eaddr;
  logic indexed_ff, nxt_indexed;
  logic [11:0] dmem_addr_ff, nxt_dmem_addr;
  logic dmem_rd_ff, nxt_dmem_rd;
  logic dmem_we_ff, nxt_dmem_we;
  logic [7:0] dmem_wdata_ff, nxt_dmem_wdata;

  logic wr_fire, wr_ok;
  logic [31:0] wr_old, wr_val;
  logic is_lit, is_file, dest_file;
  logic [7:0] operand;
  logic [7:0] alu_sum;
  logic [4:0] alu_flags;
  logic [11:0] res_addr;
  logic res_indexed;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < BYTES_PER_WORD; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Decode of the held instruction word
  assign is_lit = (instr_ff[15:8] == OPC_ADD_LIT);
  assign is_file = (instr_ff[15:10] == OPC_ADD_FILE);
  assign dest_file = instr_ff[INSTR_DEST_BIT];
  assign operand = is_file ? dmem_rdata_i : instr_ff[7:0]; // see [RULE7]

  aie_addr_resolve u_resolve (
    .file_i(instr_ff[7:0]),
    .access_i(instr_ff[INSTR_ACC_BIT]),
    .ext_en_i(ext_en_ff),
    .bank_select_register_i(bank_select_register_ff),
    .fsr2_i(fsr2_ff),
    .addr_o(res_addr),
    .indexed_o(res_indexed)
  );

  aie_adder u_adder (
    .a_i(wreg_ff),
    .b_i(operand),
    .sum_o(alu_sum),
    .flags_o(alu_flags)
  );

  // ==========================================================
  // Write acceptance: registers change only while no instruction runs
  always_comb
  begin
    wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    wr_old = 32'h0000_0000;
    wr_ok = 1'b0;
    unique case (awaddr_ff)
      OFS_CTRL:
      begin
        wr_old = {31'h0, ext_en_ff};
        wr_ok = 1'b1;
      end
      OFS_INSTR:
      begin
        wr_old = {16'h0, instr_ff};
        wr_ok = 1'b1;
      end
      OFS_WREG:
      begin
        wr_old = {24'h0, wreg_ff};
        wr_ok = 1'b1;
      end
      OFS_BANK_SELECT_REGISTER:
      begin
        wr_old = {28'h0, bank_select_register_ff};
        wr_ok = 1'b1;
      end
      OFS_FSR2:
      begin
        wr_old = {20'h0, fsr2_ff};
        wr_ok = 1'b1;
      end
      default:
      begin
        wr_old = 32'h0000_0000;
        wr_ok = 1'b0;
      end
    endcase
    // Busy refusal keeps operands stable across the four phases
    wr_ok = wr_ok && (state_ff == ST_IDLE);
    wr_val = merge(wr_old, wdata_ff, wstrb_ff);
  end

  // ==========================================================
  // AXI4-Lite write channel
  always_comb
  begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid_i && awready_ff)
    begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_ff)
    begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata_i;
      nxt_wstrb = s_axi_wstrb_i;
    end
    if (wr_fire)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_ff && s_axi_bready_i)
    begin
      nxt_bvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_got && !nxt_bvalid;
    nxt_wready = !nxt_w_got && !nxt_bvalid;
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid_i && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        OFS_CTRL: nxt_rdata[CTRL_EXT_BIT] = ext_en_ff;
        OFS_INSTR: nxt_rdata[15:0] = instr_ff;
        OFS_WREG: nxt_rdata[7:0] = wreg_ff;
        OFS_BANK_SELECT_REGISTER: nxt_rdata[3:0] = bank_select_register_ff;
        OFS_FSR2: nxt_rdata[11:0] = fsr2_ff;
        OFS_STATUS:
        begin
          nxt_rdata[4:0] = flags_ff;
          nxt_rdata[STS_BUSY_BIT] = (state_ff != ST_IDLE);
          nxt_rdata[STS_UNSUP_BIT] = unsup_ff;
        end
        OFS_EADDR:
        begin
          nxt_rdata[11:0] = eaddr_ff;
          nxt_rdata[EADDR_IDX_BIT] = indexed_ff;
        end
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
    else if (rvalid_ff && s_axi_rready_i)
    begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  // ==========================================================
  // Instruction cycle: decode, operand read, process, write
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ext_en = ext_en_ff;
    nxt_instr = instr_ff;
    nxt_wreg = wreg_ff;
    nxt_bank_select_register = bank_select_register_ff;
    nxt_fsr2 = fsr2_ff;
    nxt_flags = flags_ff;
    nxt_unsup = unsup_ff;
    nxt_sum = sum_ff;
    nxt_pend_flags = pend_flags_ff;
    nxt_eaddr = eaddr_ff;
    nxt_indexed = indexed_ff;
    nxt_dmem_addr = dmem_addr_ff;
    nxt_dmem_rd = 1'b0;
    nxt_dmem_we = 1'b0;
    nxt_dmem_wdata = dmem_wdata_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (wr_fire && wr_ok)
        begin
          unique case (awaddr_ff)
            OFS_CTRL: nxt_ext_en = wr_val[CTRL_EXT_BIT];
            OFS_WREG: nxt_wreg = wr_val[7:0];
            OFS_BANK_SELECT_REGISTER: nxt_bank_select_register = wr_val[3:0];
            OFS_FSR2: nxt_fsr2 = wr_val[11:0];
            OFS_INSTR:
            begin
              nxt_instr = wr_val[15:0];
              nxt_state = ST_Q1;
            end
            default: nxt_state = ST_IDLE;
          endcase
        end
      end
      ST_Q1:
      begin
        // Full 8-bit file field and both operand bits are honoured
        nxt_unsup = !(is_lit || is_file); // see [RULE6]
        nxt_state = (is_lit || is_file) ? ST_Q2 : ST_IDLE;
        if (is_file)
        begin
          nxt_eaddr = res_addr; // see [RULE3] [RULE4] [RULE5]
          nxt_indexed = res_indexed;
          nxt_dmem_addr = res_addr;
          nxt_dmem_rd = 1'b1;
        end
      end
      ST_Q2:
      begin
        nxt_state = ST_Q3;
      end
      ST_Q3:
      begin
        nxt_sum = alu_sum; // see [RULE1] [RULE7]
        nxt_pend_flags = alu_flags;
        // Strobe set here so the memory write lands during Q4
        if (is_file && dest_file)
        begin
          nxt_dmem_we = 1'b1; // see [RULE2]
          nxt_dmem_wdata = alu_sum;
        end
        nxt_state = ST_Q4;
      end
      ST_Q4:
      begin
        if (!(is_file && dest_file))
        begin
          nxt_wreg = sum_ff; // see [RULE1] [RULE7]
        end
        nxt_flags = pend_flags_ff; // see [RULE7]
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
      state_ff <= ST_IDLE;
      ext_en_ff <= 1'b0;
      instr_ff <= RST_INSTR;
      wreg_ff <= RST_WREG;
      bank_select_register_ff <= RST_BANK_SELECT_REGISTER;
      fsr2_ff <= RST_FSR2;
      flags_ff <= RST_FLAGS;
      unsup_ff <= 1'b0;
      sum_ff <= RST_WREG;
      pend_flags_ff <= RST_FLAGS;
      eaddr_ff <= RST_FSR2;
      indexed_ff <= 1'b0;
      dmem_addr_ff <= RST_FSR2;
      dmem_rd_ff <= 1'b0;
      dmem_we_ff <= 1'b0;
      dmem_wdata_ff <= RST_WREG;
    end
    else
    begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      state_ff <= nxt_state;
      ext_en_ff <= nxt_ext_en;
      instr_ff <= nxt_instr;
      wreg_ff <= nxt_wreg;
      bank_select_register_ff <= nxt_bank_select_register;
      fsr2_ff <= nxt_fsr2;
      flags_ff <= nxt_flags;
      unsup_ff <= nxt_unsup;
      sum_ff <= nxt_sum;
      pend_flags_ff <= nxt_pend_flags;
      eaddr_ff <= nxt_eaddr;
      indexed_ff <= nxt_indexed;
      dmem_addr_ff <= nxt_dmem_addr;
      dmem_rd_ff <= nxt_dmem_rd;
      dmem_we_ff <= nxt_dmem_we;
      dmem_wdata_ff <= nxt_dmem_wdata;
    end
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign dmem_addr_o = dmem_addr_ff;
  assign dmem_rd_o = dmem_rd_ff;
  assign dmem_we_o = dmem_we_ff;
  assign dmem_wdata_o = dmem_wdata_ff;
endmodule
`default_nettype wire

// file: rtl/aie_pkg.sv
package aie_pkg;
  // ==========================================================
  // Register bus
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_WREG = 8'h08;
  localparam logic [7:0] OFS_BANK_SELECT_REGISTER = 8'h0c;
  localparam logic [7:0] OFS_FSR2 = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_EADDR = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Field layouts and reset values
  localparam int unsigned CTRL_EXT_BIT = 0;
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_DIGIT_CARRY = 1;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_OVERFLOW = 3;
  localparam int unsigned FLG_N = 4;
  localparam int unsigned STS_BUSY_BIT = 8;
  localparam int unsigned STS_UNSUP_BIT = 9;
  localparam int unsigned EADDR_IDX_BIT = 12;
  localparam int unsigned BYTES_PER_WORD = 4;
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic [3:0] RST_BANK_SELECT_REGISTER = 4'h0;
  localparam logic [11:0] RST_FSR2 = 12'h000;
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [4:0] RST_FLAGS = 5'h00;

  // ==========================================================
  // Instruction encodings
  localparam logic [7:0] OPC_ADD_LIT = 8'h0f;
  localparam logic [5:0] OPC_ADD_FILE = 6'h09;
  localparam int unsigned INSTR_DEST_BIT = 9;
  localparam int unsigned INSTR_ACC_BIT = 8;

  // ==========================================================
  // Data memory addressing
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;

  // ==========================================================
  // Instruction cycle phases
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_Q1 = 5'h02,
    ST_Q2 = 5'h04,
    ST_Q3 = 5'h08,
    ST_Q4 = 5'h10
  } aie_state_t;
endpackage

// file: rtl/aie_addr_resolve.sv
`timescale 1ns/1ps
`default_nettype none
module aie_addr_resolve
  import aie_pkg::*;
(
  input wire logic [7:0] file_i,
  input wire logic access_i,
  input wire logic ext_en_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [11:0] fsr2_i,
  output logic [11:0] addr_o,
  output logic indexed_o
);
  // ==========================================================
  // Effective address of the file operand
  always_comb
  begin
    indexed_o = 1'b0;
    if (access_i)
    begin
      addr_o = {bank_select_register_i, file_i}; // see [RULE4]
    end
    else if (ext_en_i && (file_i <= IDX_LIMIT))
    begin
      // Pointer wraps inside the 12-bit data space
      addr_o = fsr2_i + {4'h0, file_i}; // see [RULE5]
      indexed_o = 1'b1;
    end
    else if (file_i < ACC_SPLIT)
    begin
      addr_o = {ACC_LOW_BANK, file_i}; // see [RULE3]
    end
    else
    begin
      addr_o = {ACC_HIGH_BANK, file_i}; // see [RULE3]
    end
  end
endmodule
`default_nettype wire

// file: rtl/aie_adder.sv
`timescale 1ns/1ps
`default_nettype none
module aie_adder
  import aie_pkg::*;
(
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  output logic [7:0] sum_o,
  output logic [4:0] flags_o
);
  logic [8:0] full;
  logic [4:0] low;

  // ==========================================================
  // Sum and arithmetic flags
  always_comb
  begin
    full = {1'b0, a_i} + {1'b0, b_i};
    low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
    sum_o = full[7:0];
    flags_o = RST_FLAGS;
    flags_o[FLG_C] = full[8]; // see [RULE7]
    flags_o[FLG_DIGIT_CARRY] = low[4];
    flags_o[FLG_Z] = (full[7:0] == 8'h00);
    // Signed overflow: like-signed operands giving an opposite sign
    flags_o[FLG_OVERFLOW] = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
    flags_o[FLG_N] = full[7];
  end
endmodule
`default_nettype wire

// file: verification/aie_dmem_model.sv
`timescale 1ns/1ps
`default_nettype none
module aie_dmem_model
(
  input wire logic clk_i,
  input wire logic [11:0] dmem_addr_i,
  input wire logic dmem_rd_i,
  input wire logic dmem_we_i,
  input wire logic [7:0] dmem_wdata_i,
  output logic [7:0] dmem_rdata_o
);
  // ==========================================================
  // Byte memory, one cycle read latency
  logic [7:0] mem [0:4095];
  initial dmem_rdata_o = 8'h00;
  always @(posedge clk_i)
  begin
    // Outside the read cycle the data bus toggles so a late sample shows
    if (dmem_rd_i)
      dmem_rdata_o <= mem[dmem_addr_i];
    else
      dmem_rdata_o <= ~dmem_rdata_o;
    if (dmem_we_i)
      mem[dmem_addr_i] <= dmem_wdata_i;
  end
endmodule
`default_nettype wire

// file: verification/aie_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module aie_core_monitor
  import aie_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [11:0] dmem_addr_o,
  input wire logic dmem_rd_o,
  input wire logic dmem_we_o
);
  logic [7:0] aw_ff, nxt_aw;
  logic [15:0] w_ff, nxt_w;
  logic instr_ok;
  logic dest_bit;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================
  // Last accepted write, to know what was launched
  always_comb
  begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    if (s_axi_awvalid_i && s_axi_awready_o)
      nxt_aw = s_axi_awaddr_i;
    if (s_axi_wvalid_i && s_axi_wready_o)
      nxt_w = s_axi_wdata_i[15:0];
  end
  always_ff @(posedge clk_i)
  begin
    aw_ff <= nxt_aw;
    w_ff <= nxt_w;
  end
  assign instr_ok = aw_ff == OFS_INSTR && s_axi_bresp_o == RESP_OKAY;
  assign dest_bit = w_ff[INSTR_DEST_BIT];
  // ==========================================================
  // Execution phases
  sequence s_file_go;
    $rose(s_axi_bvalid_o) && instr_ok && w_ff[15:10] == OPC_ADD_FILE;
  endsequence
  sequence s_lit_go;
    $rose(s_axi_bvalid_o) && instr_ok && w_ff[15:8] == OPC_ADD_LIT;
  endsequence
  sequence s_mem_cycle;
    dmem_rd_o ##1 !dmem_rd_o && $stable(dmem_addr_o) ##1 !dmem_rd_o && $stable(dmem_addr_o);
  endsequence
  sequence s_both_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  a_file_reads: assert property (s_file_go |=> s_mem_cycle)
    else $error("file add missed its memory read phase");
  a_dest_write: assert property (s_file_go |=> ##2 dmem_we_o == $past(dest_bit, 3))
    else $error("memory write does not follow destination bit");
  a_we_after_rd: assert property (dmem_we_o |-> $past(dmem_rd_o, 2))
    else $error("memory write without read two cycles before");
  a_lit_no_mem: assert property (s_lit_go |=> !(dmem_rd_o || dmem_we_o) [*4])
    else $error("literal add touched data memory");
  a_b_answer: assert property (s_both_taken |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write response not two cycles after take");
  a_b_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  a_r_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read data not one cycle after take");
  a_r_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
endmodule
bind aie_core aie_core_monitor u_mon (.*);
`default_nettype wire

// file: verification/add_instruction_execute_tb.sv
`timescale 1ns/1ps
`default_nettype none
module add_instruction_execute_tb
  import aie_pkg::*;
;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [11:0] dmem_addr_o;
  logic dmem_rd_o, dmem_we_o;
  logic [7:0] dmem_rdata_i, dmem_wdata_o;
  int n_mismatch = 0;
  int num_checks = 0;
  always #5 clk_i = ~clk_i;
  aie_core dut (.*);
  aie_dmem_model dmem (.clk_i(clk_i), .dmem_addr_i(dmem_addr_o), .dmem_rd_i(dmem_rd_o),
    .dmem_we_i(dmem_we_o), .dmem_wdata_i(dmem_wdata_o), .dmem_rdata_o(dmem_rdata_i));
  // ==========================================================
  // Reporting
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo(input int k);
    if (k == 50)
    begin
      n_mismatch++;
      $display("mismatch at %0t: bus timeout", $time);
      wrap_up();
    end
  endtask
  // ==========================================================
  // Register bus master
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_i);
      if (s_axi_awready_o === 1'h1) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o === 1'h1) s_axi_wvalid_i <= 1'h0;
      if (s_axi_bvalid_o === 1'h1 && s_axi_bready_i) break;
      if (s_axi_bvalid_o === 1'h1) s_axi_bready_i <= 1'h1;
    end
    s_axi_bready_i <= 1'h0;
    tmo(k);
    chk(32'(s_axi_bresp_o), 32'(er));
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_i);
      if (s_axi_arready_o === 1'h1) s_axi_arvalid_i <= 1'h0;
      if (s_axi_rvalid_o === 1'h1 && s_axi_rready_i) break;
      if (s_axi_rvalid_o === 1'h1) s_axi_rready_i <= 1'h1;
    end
    d = s_axi_rdata_o;
    s_axi_rready_i <= 1'h0;
    tmo(k);
    chk(32'(s_axi_rresp_o), 32'(er));
  endtask
  // ==========================================================
  // One add with its expected results
  task run_case(input logic e, input logic [3:0] bk, input logic [11:0] fs, input logic [7:0] w,
    input logic [15:0] ins, input logic [11:0] ea, input logic [7:0] m, input logic ix);
    logic [8:0] s;
    logic [4:0] h;
    logic [31:0] r;
    logic lit, dst, ovf;
    lit = ins[15:8] == OPC_ADD_LIT;
    dst = !lit && ins[INSTR_DEST_BIT];
    s = {1'h0, w} + {1'h0, m};
    h = {1'h0, w[3:0]} + {1'h0, m[3:0]};
    ovf = w[7] == m[7] && s[7] != w[7];
    wr(OFS_CTRL, 32'(e), RESP_OKAY);
    wr(OFS_BANK_SELECT_REGISTER, 32'(bk), RESP_OKAY);
    wr(OFS_FSR2, 32'(fs), RESP_OKAY);
    wr(OFS_WREG, 32'(w), RESP_OKAY);
    if (!lit)
      dmem.mem[ea] = m;
    wr(OFS_INSTR, 32'(ins), RESP_OKAY);
    repeat (5) @(posedge clk_i);
    rd(OFS_WREG, r, RESP_OKAY);
    chk(r, dst ? 32'(w) : 32'(s[7:0]));
    if (!lit)
    begin
      chk(32'(dmem.mem[ea]), dst ? 32'(s[7:0]) : 32'(m));
      rd(OFS_EADDR, r, RESP_OKAY);
      chk(r, {19'h0, ix, ea});
    end
    rd(OFS_STATUS, r, RESP_OKAY);
    chk(r, 32'({s[7], ovf, s[7:0] == 8'h00, h[4], s[8]}));
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    int i;
    logic [31:0] r;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'h0;
    for (i = 0; i < 7; i++)
    begin
      rd(8'(BYTES_PER_WORD * i), r, RESP_OKAY);
      chk(r, 32'h0);
    end
    rd(8'h1c, r, RESP_SLVERR);
    chk(r, 32'h0);
    wr(OFS_STATUS, 32'h1f, RESP_SLVERR);
    wr(OFS_INSTR, 32'h1234, RESP_OKAY);
    repeat (5) @(posedge clk_i);
    rd(OFS_STATUS, r, RESP_OKAY);
    chk(r, 32'h200);
    run_case(1'h0, 4'h0, 12'h000, 8'h10, 16'h0f15, 12'h000, 8'h15, 1'h0);
    run_case(1'h0, 4'h0, 12'h000, 8'hff, 16'h0f01, 12'h000, 8'h01, 1'h0);
    run_case(1'h0, 4'h0, 12'h000, 8'h7f, 16'h0f01, 12'h000, 8'h01, 1'h0);
    run_case(1'h0, 4'h2, 12'h000, 8'h17, 16'h2534, 12'h234, 8'hc2, 1'h0);
    run_case(1'h0, 4'h5, 12'h000, 8'h80, 16'h27ff, 12'h5ff, 8'h80, 1'h0);
    run_case(1'h0, 4'h7, 12'h000, 8'h08, 16'h2600, 12'h000, 8'h08, 1'h0);
    run_case(1'h0, 4'h7, 12'h000, 8'h01, 16'h2480, 12'hf80, 8'h33, 1'h0);
    run_case(1'h1, 4'h7, 12'h300, 8'h11, 16'h265f, 12'h35f, 8'h22, 1'h1);
    run_case(1'h1, 4'h7, 12'h300, 8'h0f, 16'h2460, 12'hf60, 8'h01, 1'h0);
    run_case(1'h1, 4'h7, 12'hff8, 8'h40, 16'h2410, 12'h008, 8'h40, 1'h1);
    run_case(1'h1, 4'h3, 12'h300, 8'h05, 16'h2520, 12'h320, 8'h06, 1'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
